// ---- imio_pkg.sv ----
// Purpose: shared constants and types for the immediate discrete i/o access unit
// Assumes: 1024 input points, 1024 output points, 32-bit accumulator
// Notes: point addresses are plain binary indices 0..1023
package imio_pkg;
	// point space and accumulator shape
	localparam int NPTS = 1024;
	localparam int AW = 10;
	localparam int ACC_W = 32;
	localparam int CNT_W = 6;
	localparam int WORD_W = 16;
	localparam int WIX_W = 6;
	localparam int WSH_W = 4;
	// legal bit counts of the formatted operations
	localparam logic [5:0] CNT_MIN = 6'h01;
	localparam logic [5:0] CNT_MAX = 6'h20;
	// reset values
	localparam logic [1023:0] PTS_RST = '0;
	localparam logic [31:0] ACC_RST = 32'h0000_0000;

	// one-hot operation codes presented with each executed instruction
	typedef enum logic [10:0] {
		IMIO_OR_IMM = 11'h001, // or_immediate_contact
		IMIO_ORN_IMM = 11'h002, // or_not_immediate_contact
		IMIO_AND_IMM = 11'h004, // and_immediate_contact
		IMIO_ANDN_IMM = 11'h008, // and_not_immediate_contact
		IMIO_COIL = 11'h010, // plain immediate output coil
		IMIO_ORED_COIL = 11'h020, // ored_immediate_coil
		IMIO_FMT_OUT = 11'h040, // formatted_immediate_output
		IMIO_SET_LATCH = 11'h080, // set_immediate_latch
		IMIO_RST_LATCH = 11'h100, // reset_immediate_latch
		IMIO_LOAD_WORD = 11'h200, // load_immediate_word
		IMIO_FMT_LOAD = 11'h400 // formatted_immediate_load
	} imio_op_t;
endpackage

// ---- imio_field.sv ----
// Purpose: cut a field of up to 32 consecutive points out of the point vector
// Assumes: count already checked to lie in 1..32
// Notes: bits at and above count come out zero; points past the top read zero
`timescale 1ns/10ps
module imio_field (
	input wire logic [1023:0] vec,
	input wire logic [9:0] base,
	input wire logic [5:0] count,
	output logic [31:0] field,
	output logic [31:0] keep
);
	// whole vector shifted so the base point lands on bit 0
	wire logic [1023:0] shifted;
	// one-hot bit at position count; its low 32 bits minus one give the low count bits mask
	wire logic [32:0] one_hot_cnt;

	assign shifted = vec >> base;
	assign one_hot_cnt = 33'h0_0000_0001 << count;
	assign keep = one_hot_cnt[31:0] - 32'h0000_0001 | {32{count == imio_pkg::CNT_MAX}};
	// upper accumulator bits forced to zero
	assign field = shifted[31:0] & keep;
endmodule // imio_field

// ---- imio_unit.sv ----
// Purpose: immediate discrete i/o access unit: live contacts, immediate coils,
//   latched set/reset ranges and formatted moves between accumulator and points
// Assumes: in_pts are synchronous to clk; one instruction per cmd_valid cycle
// Notes: results appear one clock after the instruction is taken, with done_r
// Summary of operation
// - parallel contact ors live input, no image write
// - parallel inverted contact ors inverted live input
// - series contact ands live input, no image
// - series inverted contact ands inverted live input
// - coil writes rung to point and image
// - every coil execution updates the physical point
// - ored coil: on if any rung true
// - formatted output copies count accumulator bits out
// - formatted moves zero accumulator bits above count
// - set latch turns on point range
// - set points stay on until reset
// - reset latch turns range off, stays off
// - word load takes sixteen live inputs
// - formatted load takes count live inputs
`timescale 1ns/10ps
module imio_unit (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scan_start,
	input wire logic cmd_valid,
	input wire imio_pkg::imio_op_t cmd_op,
	input wire logic [9:0] cmd_addr,
	input wire logic [9:0] cmd_last,
	input wire logic [5:0] cmd_count,
	input wire logic rung_in,
	input wire logic [31:0] acc_in,
	input wire logic [1023:0] in_pts,
	output logic rung_out_r,
	output logic [31:0] acc_out_r,
	output logic [1023:0] out_pts_r,
	output logic [1023:0] out_img_r,
	output logic done_r,
	output logic err_r
);
	// operation decode
	wire logic op_or;
	wire logic op_orn;
	wire logic op_and;
	wire logic op_andn;
	wire logic op_coil;
	wire logic op_ored;
	wire logic op_fmt_out;
	wire logic op_set;
	wire logic op_rst;
	wire logic op_ldw;
	wire logic op_fmt_ld;
	wire logic op_known;
	// legality of the operands
	wire logic cnt_ok;
	wire logic rng_ok;
	wire logic cmd_ok;
	// execution strobes, gated by rung for the data moving operations
	wire logic go;
	wire logic go_fmt_out;
	wire logic go_set;
	wire logic go_rst;
	wire logic go_ldw;
	wire logic go_fmt_ld;
	// live input point at the addressed position
	wire logic live_bit;
	// rung result after a contact
	wire logic rung_nxt;
	// accumulator values for the load operations
	wire logic [1023:0] word_shift;
	wire logic [31:0] word_val;
	wire logic [31:0] fmt_ld_val;
	wire logic [31:0] fmt_keep;
	wire logic [31:0] acc_nxt;
	// per-point next values
	wire logic [1023:0] out_nxt;
	wire logic [1023:0] img_nxt;
	wire logic [1023:0] ored_nxt;
	// or-accumulation of ored coils within the current scan
	logic [1023:0] ored_r;

	assign op_or = cmd_op == imio_pkg::IMIO_OR_IMM;
	assign op_orn = cmd_op == imio_pkg::IMIO_ORN_IMM;
	assign op_and = cmd_op == imio_pkg::IMIO_AND_IMM;
	assign op_andn = cmd_op == imio_pkg::IMIO_ANDN_IMM;
	assign op_coil = cmd_op == imio_pkg::IMIO_COIL;
	assign op_ored = cmd_op == imio_pkg::IMIO_ORED_COIL;
	assign op_fmt_out = cmd_op == imio_pkg::IMIO_FMT_OUT;
	assign op_set = cmd_op == imio_pkg::IMIO_SET_LATCH;
	assign op_rst = cmd_op == imio_pkg::IMIO_RST_LATCH;
	assign op_ldw = cmd_op == imio_pkg::IMIO_LOAD_WORD;
	assign op_fmt_ld = cmd_op == imio_pkg::IMIO_FMT_LOAD;
	assign op_known = op_or | op_orn | op_and | op_andn | op_coil | op_ored
		| op_fmt_out | op_set | op_rst | op_ldw | op_fmt_ld;

	// a bad count or a reversed range is refused and flagged, nothing moves
	assign cnt_ok = cmd_count >= imio_pkg::CNT_MIN && cmd_count <= imio_pkg::CNT_MAX;
	assign rng_ok = cmd_last >= cmd_addr;
	assign cmd_ok = op_known
		& (~(op_fmt_out | op_fmt_ld) | cnt_ok)
		& (~(op_set | op_rst) | rng_ok);
	assign go = cmd_valid & cmd_ok;
	// data moves and latches only act on a true rung; coils act on both levels
	assign go_fmt_out = go & op_fmt_out & rung_in;
	assign go_set = go & op_set & rung_in;
	assign go_rst = go & op_rst & rung_in;
	assign go_ldw = go & op_ldw & rung_in;
	assign go_fmt_ld = go & op_fmt_ld & rung_in;

	// contacts read the pins directly; no input image exists here to disturb
	assign live_bit = in_pts[cmd_addr];
	assign rung_nxt = op_or ? (rung_in | live_bit) :
		op_orn ? (rung_in | ~live_bit) :
		op_and ? (rung_in & live_bit) :
		op_andn ? (rung_in & ~live_bit) :
		rung_in;

	// word load: word index picks sixteen consecutive live inputs
	assign word_shift = in_pts >> {cmd_addr[5:0], 4'h0};
	assign word_val = {16'h0000, word_shift[15:0]};

	// formatted load field, bit i of the result is point base+i
	imio_field u_field (
		.vec(in_pts),
		.base(cmd_addr),
		.count(cmd_count),
		.field(fmt_ld_val),
		.keep(fmt_keep)
	);

	// accumulator result; formatted moves clear the bits above count
	assign acc_nxt = go_fmt_ld ? fmt_ld_val :
		go_ldw ? word_val :
		go_fmt_out ? (acc_in & fmt_keep) :
		acc_in;

	// per output point: coil, ored coil, formatted copy, set and reset
	for (genvar p = 0; p < imio_pkg::NPTS; p++) begin : g_pt
		localparam logic [9:0] PI = 10'(p);
		// distance of this point above the base address
		wire logic [9:0] off;
		wire logic at_addr;
		wire logic in_fmt;
		wire logic in_rng;
		wire logic ored_val;

		assign off = PI - cmd_addr;
		assign at_addr = PI == cmd_addr;
		assign in_fmt = PI >= cmd_addr && off < {4'h0, cmd_count};
		assign in_rng = PI >= cmd_addr && PI <= cmd_last;
		assign ored_val = ored_r[p] | rung_in;
		// every coil execution drives the pin, so a pin may toggle in one scan
		assign out_nxt[p] = (go & op_coil & at_addr) ? rung_in :
			(go & op_ored & at_addr) ? ored_val :
			(go_fmt_out & in_fmt) ? acc_in[off[4:0]] :
			(go_set & in_rng) ? 1'b1 :
			(go_rst & in_rng) ? 1'b0 :
			out_pts_r[p];
		// image follows the coils only; latches leave it alone
		assign img_nxt[p] = (go & op_coil & at_addr) ? rung_in :
			(go & op_ored & at_addr) ? ored_val :
			out_img_r[p];
		// a true ored rung at the same edge as scan_start still counts
		assign ored_nxt[p] = (go & op_ored & at_addr & rung_in) ? 1'b1 :
			scan_start ? 1'b0 :
			ored_r[p];
	end

	// output points, image and ored memory
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_pts_r <= imio_pkg::PTS_RST;
			out_img_r <= imio_pkg::PTS_RST;
			ored_r <= imio_pkg::PTS_RST;
		end else begin
			out_pts_r <= out_nxt;
			out_img_r <= img_nxt;
			ored_r <= ored_nxt;
		end
	end

	// rung, accumulator and completion strobes
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rung_out_r <= 1'b0;
			acc_out_r <= imio_pkg::ACC_RST;
			done_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			if (go) begin
				rung_out_r <= rung_nxt;
				acc_out_r <= acc_nxt;
			end
			done_r <= cmd_valid;
			err_r <= cmd_valid & ~cmd_ok;
		end
	end

	// checks on the executed instruction, one clock after it is taken
	or_contact_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && cmd_op == imio_pkg::IMIO_OR_IMM
		|=> rung_out_r == ($past(rung_in) | $past(live_bit)) && done_r)
		else $error("or contact result wrong");

	orn_contact_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && cmd_op == imio_pkg::IMIO_ORN_IMM
		|=> rung_out_r == ($past(rung_in) | ~$past(live_bit)))
		else $error("inverted or contact result wrong");

	and_contact_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && cmd_op == imio_pkg::IMIO_AND_IMM
		|=> rung_out_r == ($past(rung_in) & $past(live_bit)))
		else $error("and contact result wrong");

	andn_contact_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && cmd_op == imio_pkg::IMIO_ANDN_IMM
		|=> rung_out_r == ($past(rung_in) & ~$past(live_bit)))
		else $error("inverted and contact result wrong");

	coil_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && cmd_op == imio_pkg::IMIO_COIL
		|=> out_pts_r[$past(cmd_addr)] == $past(rung_in)
		&& out_img_r[$past(cmd_addr)] == $past(rung_in))
		else $error("coil did not reach pin and image");

	ored_on_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && cmd_op == imio_pkg::IMIO_ORED_COIL && rung_in
		|=> out_pts_r[$past(cmd_addr)] && !cmd_valid ##1 !cmd_valid
		|=> out_pts_r[$past(cmd_addr, 3)])
		else $error("ored coil not held on");

	fmt_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		go_fmt_ld || go_fmt_out
		|=> (acc_out_r >> $past(cmd_count)) == 32'h0000_0000)
		else $error("accumulator bits above count not cleared");

	word_load_a: assert property (@(posedge clk) disable iff (sys_rst)
		go_ldw
		|=> acc_out_r[15:0] == $past(word_shift[15:0]) && acc_out_r[31:16] == 16'h0000)
		else $error("word load value wrong");

	set_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!cmd_valid |=> out_pts_r == $past(out_pts_r))
		else $error("points changed with no instruction");

	set_range_a: assert property (@(posedge clk) disable iff (sys_rst)
		go_set |=> out_pts_r[$past(cmd_addr)] && out_pts_r[$past(cmd_last)]
		&& out_img_r == $past(out_img_r))
		else $error("set latch range not on");

	rst_range_a: assert property (@(posedge clk) disable iff (sys_rst)
		go_rst |=> !out_pts_r[$past(cmd_addr)] && !out_pts_r[$past(cmd_last)])
		else $error("reset latch range not off");

	refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && !cmd_ok |=> err_r && done_r && $stable(out_pts_r))
		else $error("bad operands not refused");

	// coil, latch, word load, formatted move and contact checks, also one clock after the command
	// a coil that disagrees with its pin must move the pin in this same scan
	coil_toggle_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && cmd_op == imio_pkg::IMIO_COIL && out_pts_r[cmd_addr] != rung_in
		|=> $changed(out_pts_r))
		else $error("repeated coil did not move the pin");

	coil_rung_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && cmd_op == imio_pkg::IMIO_COIL
		|=> rung_out_r == $past(rung_in) && done_r && !err_r)
		else $error("coil rung not passed on");

	fmt_out_base_a: assert property (@(posedge clk) disable iff (sys_rst)
		go_fmt_out
		|=> out_pts_r[$past(cmd_addr)] == $past(acc_in[0]))
		else $error("formatted output base point wrong");

	// formatted output is a pin-only move, the image keeps its coil values
	fmt_out_img_a: assert property (@(posedge clk) disable iff (sys_rst)
		go_fmt_out
		|=> out_img_r == $past(out_img_r))
		else $error("formatted output touched the image");

	fmt_load_base_a: assert property (@(posedge clk) disable iff (sys_rst)
		go_fmt_ld
		|=> acc_out_r[0] == $past(live_bit))
		else $error("formatted load base point wrong");

	// a latch with a false rung must leave every pin as it was
	latch_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && (op_set || op_rst) && !rung_in
		|=> $stable(out_pts_r) && $stable(out_img_r))
		else $error("latch moved with rung false");

	rst_img_a: assert property (@(posedge clk) disable iff (sys_rst)
		go_rst
		|=> out_img_r == $past(out_img_r))
		else $error("reset latch touched the image");

	word_rung_low_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && cmd_ok && op_ldw && !rung_in
		|=> acc_out_r == $past(acc_in))
		else $error("word load acted on a false rung");

	// contacts only combine the rung; no output or image may move
	contact_img_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && (op_or || op_orn || op_and || op_andn)
		|=> $stable(out_img_r) && $stable(out_pts_r))
		else $error("contact disturbed outputs or image");

	fmt_ld_rung_low_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_valid && cmd_ok && op_fmt_ld && !rung_in
		|=> acc_out_r == $past(acc_in))
		else $error("formatted load acted on a false rung");
endmodule // imio_unit

// ---- imio_io_model.sv ----
// Purpose: far-side model of the local-base discrete input modules
// Assumes: the bench hands over a new live pattern just after the rising edge that starts each command
// Notes: no filter delay is modelled, so the points may move every cycle
`timescale 1ns/10ps
module imio_io_model (
	input wire logic [1023:0] pat,
	output logic [1023:0] in_pts
);
	// field wiring straight to the unit; a held image here would hide stale sampling
	always_comb begin
		in_pts = pat;
	end
endmodule // imio_io_model

// ---- tb_immediate_io_access_unit.sv ----
// Purpose: self-checking bench for the immediate discrete i/o access unit
// Assumes: one command per cycle, results one clock later with done_r
// Notes: a shadow of points, image and ored memory predicts every result except the image bits of ored coils
`timescale 1ns/10ps
module tb_immediate_io_access_unit;
	// one predicted result; c marks image bits whose value is defined
	typedef struct {logic r; logic [31:0] a; logic e; logic [1023:0] p, m, c;} imio_exp_t;
	logic clk, sys_rst, scan_start, cmd_valid, rung_in, rung_out_r, done_r, err_r, pr;
	imio_pkg::imio_op_t cmd_op;
	logic [9:0] cmd_addr, cmd_last;
	logic [5:0] cmd_count;
	logic [31:0] acc_in, acc_out_r, pa;
	logic [1023:0] pat, in_pts, out_pts_r, out_img_r, ep, ei, care, mem;
	int err_count, n_compared, cyc;
	imio_exp_t q[$]; // results still owed by the unit

	imio_io_model io (.pat(pat), .in_pts(in_pts));
	imio_unit dut (.clk(clk), .sys_rst(sys_rst), .scan_start(scan_start),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_last(cmd_last),
		.cmd_count(cmd_count), .rung_in(rung_in), .acc_in(acc_in), .in_pts(in_pts),
		.rung_out_r(rung_out_r), .acc_out_r(acc_out_r), .out_pts_r(out_pts_r),
		.out_img_r(out_img_r), .done_r(done_r), .err_r(err_r));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [1023:0] g, input logic [1023:0] x);
		n_compared++;
		if (g !== x) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask

	// one-bit results: rung and refusal flag
	task automatic chk_bit(input logic g, input logic x);
		chk(1024'(g), 1024'(x));
	endtask

	// accumulator results
	task automatic chk_acc(input logic [31:0] g, input logic [31:0] x);
		chk(1024'(g), 1024'(x));
	endtask

	task automatic tally_and_finish;
		if (err_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// hang guard, far above the roughly 125 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// watcher: every done pulse settles the oldest note
	always @(negedge clk) begin
		imio_exp_t e;
		if (done_r === 1'b1) begin
			chk_bit(q.size() != 0, 1'b1);
			if (q.size() != 0) begin
				e = q.pop_front();
				chk_bit(err_r, e.e);
				chk_bit(rung_out_r, e.r);
				chk_acc(acc_out_r, e.a);
				chk(out_pts_r, e.p);
				chk(out_img_r & e.c, e.m & e.c);
			end
		end
	end

	function automatic logic [1023:0] rnd();
		logic [1023:0] v;
		for (int i = 0; i < 32; i++) begin
			v[i*32 +: 32] = $urandom();
		end
		return v;
	endfunction

	// drive one command with fresh live points and note what must come back
	task automatic cmd(input logic [10:0] op, input int ad, la, cn, input logic r);
		imio_exp_t e;
		logic bad;
		int k;
		@(posedge clk);
		#1;
		pat = rnd();
		acc_in = $urandom();
		cmd_valid = 1'b1;
		cmd_op = imio_pkg::imio_op_t'(op);
		cmd_addr = 10'(ad);
		cmd_last = 10'(la);
		cmd_count = 6'(cn);
		rung_in = r;
		bad = ($countones(op) != 1) || ((op == 11'h040 || op == 11'h400) && (cn < 1 || cn > 32))
			|| ((op == 11'h080 || op == 11'h100) && la < ad);
		e.r = r;
		e.a = acc_in;
		e.e = bad;
		// refused: rung and accumulator keep their last accepted values
		if (bad) begin
			e.r = pr;
			e.a = pa;
		end else case (op)
			11'h001: e.r = r | pat[ad];
			11'h002: e.r = r | ~pat[ad];
			11'h004: e.r = r & pat[ad];
			11'h008: e.r = r & ~pat[ad];
			11'h010: begin
				ep[ad] = r;
				ei[ad] = r;
				care[ad] = 1'b1;
			end
			11'h020: begin
				mem[ad] = mem[ad] | r;
				ep[ad] = mem[ad];
				care[ad] = 1'b0;
			end
			default: if (r) begin
				if (op == 11'h080 || op == 11'h100) begin
					for (int j = ad; j <= la; j++) begin
						ep[j] = (op == 11'h080);
					end
				end else begin
					for (int i = 0; i < 32; i++) begin
						k = (op == 11'h200) ? (ad % 64) * 16 + i : ad + i;
						e.a[i] = 1'b0;
						if (op == 11'h040 && i < cn) begin
							e.a[i] = acc_in[i];
							if (k < 1024) ep[k] = acc_in[i];
						end
						if (op == 11'h400 && i < cn && k < 1024) e.a[i] = pat[k];
						if (op == 11'h200 && i < 16) e.a[i] = pat[k];
					end
				end
			end
		endcase
		if (!bad) begin
			pr = e.r;
			pa = e.a;
		end
		e.p = ep;
		e.m = ei;
		e.c = care;
		q.push_back(e);
	endtask

	// one scan boundary; also idles the command port
	task automatic scan;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		scan_start = 1'b1;
		mem = '0;
		@(posedge clk);
		#1;
		scan_start = 1'b0;
	endtask

	// main sequence
	initial begin
		int ad;
		int la;
		void'($urandom(36));
		{sys_rst, scan_start, cmd_valid, rung_in} = 4'h8;
		cmd_op = imio_pkg::IMIO_COIL;
		{cmd_addr, cmd_last, cmd_count, acc_in, pa, pr} = '0;
		{pat, ep, ei, mem} = '0;
		care = '1;
		{err_count, n_compared, cyc} = '0;
		repeat (6) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		for (int o = 0; o < 8; o++) begin
			cmd(11'h001 << (o / 2), $urandom % 1024, 0, 0, o[0]);
		end
		cmd(11'h010, 7, 0, 0, 1);
		cmd(11'h010, 7, 0, 0, 0);
		scan();
		cmd(11'h020, 9, 0, 0, 1);
		cmd(11'h020, 9, 0, 0, 0);
		cmd(11'h020, 9, 0, 0, 1);
		scan();
		cmd(11'h020, 9, 0, 0, 0);
		cmd(11'h040, 24, 0, 8, 1);
		cmd(11'h040, 1020, 0, 8, 1);
		cmd(11'h040, 50, 0, 32, 1);
		cmd(11'h040, 60, 0, 1, 0);
		cmd(11'h400, 1016, 0, 32, 1);
		cmd(11'h400, 3, 0, 1, 1);
		cmd(11'h200, 63, 0, 0, 1);
		cmd(11'h200, 0, 0, 0, 1);
		cmd(11'h080, 2, 5, 0, 1);
		cmd(11'h080, 200, 300, 0, 0);
		cmd(11'h100, 4, 4, 0, 0);
		cmd(11'h100, 3, 900, 0, 1);
		cmd(11'h080, 10, 9, 0, 1);
		cmd(11'h000, 1, 0, 0, 1);
		cmd(11'h040, 5, 0, 33, 1);
		cmd(11'h400, 5, 0, 0, 1);
		for (int n = 0; n < 80; n++) begin
			ad = $urandom % 1024;
			la = ad + $urandom % 40;
			cmd(11'h001 << ($urandom % 11), ad, (la > 1023) ? 1023 : la, 1 + $urandom % 32,
				$urandom % 2);
		end
		scan();
		repeat (3) @(posedge clk);
		chk(q.size(), 0);
		tally_and_finish();
	end
endmodule // tb_immediate_io_access_unit
